// *** src/dsitim_top.sv ***
// Display link configuration, timeouts, video timing and interrupt status block.
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Pixel FIFO
// ****************************************
module dsitim_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic             push;
	logic             pop;
	logic [LW-1:0]    level_nxt;

	// Ready and valid are registered flags kept in step with the level.
	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;
	assign out_data = mem[rd_ptr_r];
	// Both flags follow the level after this edge, so filling the last slot drops ready at once.
	assign level_nxt = level + LW'(push) - LW'(pop);

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			level     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			level     <= level_nxt;
			in_ready  <= level_nxt < LW'(DEPTH);
			out_valid <= level_nxt != '0;
		end
	end
endmodule

// ****************************************
// Top level
// ****************************************
module dsitim_top
	import dsitim_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int PIX_W      = 32
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [15:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic                  irq_r,
	input  wire logic             link_byte_clk,
	input  wire logic             peer_rx_active,
	input  wire logic             peer_ack_valid,
	input  wire logic [DSITIM_ACK_ERR_W-1:0] peer_ack_err,
	input  wire logic             pix_valid,
	input  wire logic [PIX_W-1:0] pix_data,
	output logic                  pix_ready,
	output logic                  cmd_stall_r,
	output logic [PIX_W-1:0]      lane_data_r,
	output logic                  lane_data_valid_r,
	output logic [3:0]            lane_en_r,
	output logic                  hs_mode_r,
	output logic                  stop_state_r,
	output logic                  eot_r,
	output logic                  bta_r,
	output logic                  panel_reset_r,
	output logic                  hsync_r,
	output logic                  vsync_r,
	output logic                  de_r,
	output logic [1:0]            cmd_vc_r,
	output logic [1:0]            video_vc_r,
	output logic [4:0]            cmd_width_bits_r,
	output logic [4:0]            video_bpp_r,
	output logic                  format_bad_r
);
	// Command width in bits; zero marks a reserved code, options carry 1 and 2.
	function automatic logic [4:0] cmd_width(input logic [2:0] code);
		unique case (code)
			3'h1:    cmd_width = 5'h10;
			3'h2:    cmd_width = 5'h09;
			3'h3:    cmd_width = 5'h08;
			3'h4:    cmd_width = 5'h01;
			3'h5:    cmd_width = 5'h02;
			default: cmd_width = 5'h00;
		endcase
	endfunction

	// Bits per pixel on the wire; loosely packed 666 takes a full 24.
	function automatic logic [4:0] pix_bpp(input logic [3:0] code);
		unique case (code)
			4'h1:    pix_bpp = 5'h10;
			4'h2:    pix_bpp = 5'h12;
			4'h3:    pix_bpp = 5'h18;
			4'h4:    pix_bpp = 5'h18;
			default: pix_bpp = 5'h00;
		endcase
	endfunction

	// Free slots needed before the command stall lifts; reserved code acts as half.
	function automatic logic [5:0] wm_free(input logic [1:0] code);
		unique case (code)
			2'h1:    wm_free = 6'(FIFO_DEPTH / 4);
			2'h2:    wm_free = 6'h07;
			default: wm_free = 6'(FIFO_DEPTH / 2);
		endcase
	endfunction

	// Lane enable mask for a lane count; zero and counts above four drive one lane.
	function automatic logic [3:0] lane_mask(input logic [2:0] cnt);
		unique case (cnt)
			3'h2:    lane_mask = 4'h3;
			3'h3:    lane_mask = 4'h7;
			3'h4:    lane_mask = 4'hF;
			default: lane_mask = 4'h1;
		endcase
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] ctrl_r, stat_r, irqen_r, func_r, hsto_r, lpto_r, tato_r, prst_r;
	logic [31:0] vres_r, wmark_r, hsp_r, hbp_r, hfp_r, hact_r, vsp_r, vbp_r, vfp_r;
	logic [31:0] switch_r, spkt_r, rd_mux;
	logic        wr_en, hit, bta_pend_r, prst_pend_r;
	logic [31:0] stat_set;

	assign wr_en = psel & penable & pready & pwrite;

	// Address decode shared by reads and the error answer.
	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			DSITIM_CTRL_OFS:   rd_mux = {29'h0, prst_pend_r, bta_pend_r, ctrl_r[DSITIM_CTRL_RUN]};
			DSITIM_STAT_OFS:   rd_mux = stat_r;
			DSITIM_IRQEN_OFS:  rd_mux = irqen_r;
			DSITIM_FUNC_OFS:   rd_mux = func_r;
			DSITIM_HSTO_OFS:   rd_mux = hsto_r;
			DSITIM_LPTO_OFS:   rd_mux = lpto_r;
			DSITIM_TATO_OFS:   rd_mux = tato_r;
			DSITIM_PRST_OFS:   rd_mux = prst_r;
			DSITIM_VRES_OFS:   rd_mux = vres_r;
			DSITIM_WMARK_OFS:  rd_mux = wmark_r;
			DSITIM_HSP_OFS:    rd_mux = hsp_r;
			DSITIM_HBP_OFS:    rd_mux = hbp_r;
			DSITIM_HFP_OFS:    rd_mux = hfp_r;
			DSITIM_HACT_OFS:   rd_mux = hact_r;
			DSITIM_VSP_OFS:    rd_mux = vsp_r;
			DSITIM_VBP_OFS:    rd_mux = vbp_r;
			DSITIM_VFP_OFS:    rd_mux = vfp_r;
			DSITIM_SWITCH_OFS: rd_mux = switch_r;
			DSITIM_SPKT_OFS:   rd_mux = spkt_r;
			default:           hit = 1'b0;
		endcase
	end

	// No wait state: the answer is prepared during setup and given in the first access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			if (psel && !penable) begin
				prdata <= (hit && !pwrite) ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// Software writes; reserved bits are masked so they always read as zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0; irqen_r <= '0; func_r <= DSITIM_FUNC_RST; hsto_r <= '0;
			lpto_r <= '0; tato_r <= '0; prst_r <= '0; vres_r <= '0; wmark_r <= '0;
			hsp_r <= '0; hbp_r <= '0; hfp_r <= '0; hact_r <= '0; vsp_r <= '0;
			vbp_r <= '0; vfp_r <= '0; switch_r <= '0; spkt_r <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				DSITIM_CTRL_OFS:   ctrl_r   <= {31'h0, pwdata[DSITIM_CTRL_RUN]};
				DSITIM_IRQEN_OFS:  irqen_r  <= pwdata & DSITIM_IRQEN_MASK;
				DSITIM_FUNC_OFS:   func_r   <= pwdata & DSITIM_FUNC_MASK;
				DSITIM_HSTO_OFS:   hsto_r   <= {8'h0, pwdata[23:0]};
				DSITIM_LPTO_OFS:   lpto_r   <= {8'h0, pwdata[23:0]};
				DSITIM_TATO_OFS:   tato_r   <= {26'h0, pwdata[5:0]};
				DSITIM_PRST_OFS:   prst_r   <= {16'h0, pwdata[15:0]};
				DSITIM_VRES_OFS:   vres_r   <= pwdata;
				DSITIM_WMARK_OFS:  wmark_r  <= {30'h0, pwdata[1:0]};
				DSITIM_HSP_OFS:    hsp_r    <= {16'h0, pwdata[15:0]};
				DSITIM_HBP_OFS:    hbp_r    <= {16'h0, pwdata[15:0]};
				DSITIM_HFP_OFS:    hfp_r    <= {16'h0, pwdata[15:0]};
				DSITIM_HACT_OFS:   hact_r   <= {16'h0, pwdata[15:0]};
				DSITIM_VSP_OFS:    vsp_r    <= {16'h0, pwdata[15:0]};
				DSITIM_VBP_OFS:    vbp_r    <= {16'h0, pwdata[15:0]};
				DSITIM_VFP_OFS:    vfp_r    <= {16'h0, pwdata[15:0]};
				DSITIM_SWITCH_OFS: switch_r <= {16'h0, pwdata[15:0]};
				DSITIM_SPKT_OFS:   spkt_r   <= pwdata & DSITIM_SPKT_MASK;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Link pin synchronisers
	// ****************************************
	logic [2:0] bclk_s;
	logic [1:0] rxa_s, ackv_s;
	logic [DSITIM_ACK_ERR_W-1:0] err_s1, err_s2;
	logic       tick;

	// Stage one feeds stage two only; the byte clock gets a third stage for its edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_s <= '0; rxa_s <= '0; ackv_s <= '0; err_s1 <= '0; err_s2 <= '0;
		end else begin
			bclk_s <= {bclk_s[1:0], link_byte_clk};
			rxa_s  <= {rxa_s[0], peer_rx_active};
			ackv_s <= {ackv_s[0], peer_ack_valid};
			err_s1 <= peer_ack_err;
			err_s2 <= err_s1;
		end
	end
	assign tick = bclk_s[1] & ~bclk_s[2];

	// ****************************************
	// Video timing
	// ****************************************
	dsitim_phase_t hph_r, vph_r;
	logic [15:0]   hcnt_r, vcnt_r, hlen, vlen;
	logic          line_end, run;

	assign run = ctrl_r[DSITIM_CTRL_RUN];

	// Phase lengths; a zero count still occupies one step.
	always_comb begin
		unique case (hph_r)
			PH_SYNC: hlen = hsp_r[15:0];
			PH_BP:   hlen = hbp_r[15:0];
			PH_ACT:  hlen = hact_r[15:0];
			PH_FP:   hlen = hfp_r[15:0];
		endcase
		unique case (vph_r)
			PH_SYNC: vlen = vsp_r[15:0];
			PH_BP:   vlen = vbp_r[15:0];
			PH_ACT:  vlen = vres_r[31:16];
			PH_FP:   vlen = vfp_r[15:0];
		endcase
	end
	assign line_end = tick && hph_r == PH_FP && (hcnt_r + 16'h1 >= hfp_r[15:0]);

	// Horizontal phases advance on byte clocks, vertical ones on line ends.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hph_r <= PH_SYNC; vph_r <= PH_SYNC; hcnt_r <= '0; vcnt_r <= '0;
		end else if (!run) begin
			hph_r <= PH_SYNC; vph_r <= PH_SYNC; hcnt_r <= '0; vcnt_r <= '0;
		end else if (tick) begin
			if (hcnt_r + 16'h1 >= hlen) begin
				hcnt_r <= '0;
				hph_r  <= dsitim_phase_t'(hph_r + 2'h1);
			end else begin
				hcnt_r <= hcnt_r + 16'h1;
			end
			if (line_end) begin
				if (vcnt_r + 16'h1 >= vlen) begin
					vcnt_r <= '0;
					vph_r  <= dsitim_phase_t'(vph_r + 2'h1);
				end else begin
					vcnt_r <= vcnt_r + 16'h1;
				end
			end
		end
	end

	// ****************************************
	// Pixel path
	// ****************************************
	logic             fo_valid, fo_ready;
	logic [PIX_W-1:0] fo_data;
	logic [$clog2(FIFO_DEPTH+1)-1:0] flevel;
	dsitim_link_t     ls_r;

	dsitim_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (pix_valid),
		.in_data   (pix_data),
		.in_ready  (pix_ready),
		.out_valid (fo_valid),
		.out_data  (fo_data),
		.out_ready (fo_ready),
		.level     (flevel)
	);
	// Pixels leave only during active area of active lines while in high speed.
	assign fo_ready = tick && ls_r == LS_HS && hph_r == PH_ACT && vph_r == PH_ACT;

	// Lane data, sync strobes and the command stall.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_data_r <= '0; lane_data_valid_r <= 1'b0; hsync_r <= 1'b0;
			vsync_r <= 1'b0; de_r <= 1'b0; cmd_stall_r <= 1'b1;
		end else begin
			lane_data_valid_r <= fo_ready & fo_valid;
			if (fo_ready && fo_valid) begin
				lane_data_r <= fo_data;
			end
			hsync_r <= run && hph_r == PH_SYNC;
			vsync_r <= run && vph_r == PH_SYNC;
			de_r    <= run && hph_r == PH_ACT && vph_r == PH_ACT;
			cmd_stall_r <= (6'(FIFO_DEPTH) - 6'(flevel)) < wm_free(wmark_r[1:0]);
		end
	end

	// ****************************************
	// Link state machine
	// ****************************************
	dsitim_link_t ls_nxt;
	logic [23:0]  tmr_r, tmr_nxt;
	logic         tmr_zero, bta_take, prst_take, eot_nxt, bta_nxt;

	assign tmr_zero = tmr_r == 24'h0;

	// Every timed state loads the timer on entry and leaves when it reaches zero.
	always_comb begin
		ls_nxt    = ls_r;
		tmr_nxt   = (tick && !tmr_zero) ? tmr_r - 24'h1 : tmr_r;
		bta_take  = 1'b0;
		prst_take = 1'b0;
		eot_nxt   = 1'b0;
		bta_nxt   = 1'b0;
		stat_set  = '0;
		if (tick) begin
			unique case (ls_r)
				LS_STOP: begin
					if (prst_pend_r) begin
						ls_nxt = LS_RST; tmr_nxt = {8'h0, prst_r[15:0]}; prst_take = 1'b1;
					end else if (bta_pend_r) begin
						ls_nxt = LS_TA; tmr_nxt = {18'h0, tato_r[5:0]}; bta_take = 1'b1; bta_nxt = 1'b1;
					end else if (run) begin
						ls_nxt = LS_UP; tmr_nxt = {8'h0, switch_r[15:0]};
					end
				end
				LS_UP: begin
					if (tmr_zero) begin
						ls_nxt = LS_HS; tmr_nxt = hsto_r[23:0];
					end
				end
				LS_HS: begin
					if (tmr_zero) begin
						ls_nxt = LS_DOWN; tmr_nxt = {8'h0, switch_r[15:0]}; eot_nxt = 1'b1;
						stat_set[DSITIM_ST_HS_TO] = 1'b1;
					end else if (line_end || !run) begin
						ls_nxt = LS_DOWN; tmr_nxt = {8'h0, switch_r[15:0]}; eot_nxt = 1'b1;
					end
				end
				LS_DOWN: begin
					if (tmr_zero) begin
						ls_nxt = LS_STOP;
					end
				end
				LS_TA: begin
					if (rxa_s[1]) begin
						ls_nxt = LS_RX; tmr_nxt = lpto_r[23:0];
					end else if (tmr_zero) begin
						ls_nxt = LS_STOP; stat_set[DSITIM_ST_TA_TO] = 1'b1;
					end
				end
				LS_RX: begin
					if (ackv_s[1]) begin
						ls_nxt = LS_STOP;
						// Acknowledge error bits land on status bits 11..0; bit 9 stays reserved.
						stat_set[DSITIM_ACK_ERR_W-1:0] = err_s2;
						stat_set[DSITIM_ST_RSVD_LOW] = 1'b0;
						stat_set[DSITIM_ST_ACK_OK] = err_s2 == '0;
					end else if (tmr_zero) begin
						ls_nxt = LS_STOP; stat_set[DSITIM_ST_LP_TO] = 1'b1;
					end
				end
				LS_RST: begin
					if (tmr_zero) begin
						ls_nxt = LS_STOP;
					end
				end
				default: ls_nxt = LS_STOP;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_r <= LS_STOP; tmr_r <= '0; eot_r <= 1'b0; bta_r <= 1'b0;
		end else begin
			ls_r  <= ls_nxt;
			tmr_r <= tmr_nxt;
			eot_r <= eot_nxt;
			bta_r <= bta_nxt;
		end
	end

	// Pending requests: a new write in the cycle it is taken is kept.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bta_pend_r <= 1'b0; prst_pend_r <= 1'b0;
		end else begin
			bta_pend_r  <= (bta_pend_r & ~bta_take) |
				(wr_en && paddr == DSITIM_CTRL_OFS && pwdata[DSITIM_CTRL_BTA]);
			prst_pend_r <= (prst_pend_r & ~prst_take) |
				(wr_en && paddr == DSITIM_CTRL_OFS && pwdata[DSITIM_CTRL_PRST]);
		end
	end

	// ****************************************
	// Status, interrupt and decoded outputs
	// ****************************************
	// Status is write-one-to-clear; a hardware set in the same cycle wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
			irq_r  <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~((wr_en && paddr == DSITIM_STAT_OFS) ? pwdata : 32'h0)) | stat_set;
			irq_r  <= |(stat_r & irqen_r);
		end
	end

	// Link mode pins and decoded configuration fields.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_en_r <= 4'h1; hs_mode_r <= 1'b0; stop_state_r <= 1'b1; panel_reset_r <= 1'b0;
			cmd_vc_r <= '0; video_vc_r <= '0; cmd_width_bits_r <= '0; video_bpp_r <= '0;
			format_bad_r <= 1'b1;
		end else begin
			lane_en_r        <= lane_mask(func_r[2:0]);
			hs_mode_r        <= ls_r == LS_HS;
			stop_state_r     <= ls_r == LS_STOP;
			panel_reset_r    <= ls_r == LS_RST;
			cmd_vc_r         <= func_r[6:5];
			video_vc_r       <= func_r[4:3];
			cmd_width_bits_r <= cmd_width(func_r[15:13]);
			video_bpp_r      <= pix_bpp(func_r[10:7]);
			format_bad_r     <= cmd_width(func_r[15:13]) == 5'h00 || pix_bpp(func_r[10:7]) == 5'h00;
		end
	end
endmodule

`default_nettype wire

// *** src/dsitim_pkg.sv ***
// Shared constants for the display link timing and interrupt block.
package dsitim_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [15:0] DSITIM_CTRL_OFS    = 16'hB000;
	localparam logic [15:0] DSITIM_STAT_OFS    = 16'hB004;
	localparam logic [15:0] DSITIM_IRQEN_OFS   = 16'hB008;
	localparam logic [15:0] DSITIM_FUNC_OFS    = 16'hB00C;
	localparam logic [15:0] DSITIM_HSTO_OFS    = 16'hB010;
	localparam logic [15:0] DSITIM_LPTO_OFS    = 16'hB014;
	localparam logic [15:0] DSITIM_TATO_OFS    = 16'hB018;
	localparam logic [15:0] DSITIM_PRST_OFS    = 16'hB01C;
	localparam logic [15:0] DSITIM_VRES_OFS    = 16'hB020;
	localparam logic [15:0] DSITIM_WMARK_OFS   = 16'hB024;
	localparam logic [15:0] DSITIM_HSP_OFS     = 16'hB028;
	localparam logic [15:0] DSITIM_HBP_OFS     = 16'hB02C;
	localparam logic [15:0] DSITIM_HFP_OFS     = 16'hB030;
	localparam logic [15:0] DSITIM_HACT_OFS    = 16'hB034;
	localparam logic [15:0] DSITIM_VSP_OFS     = 16'hB038;
	localparam logic [15:0] DSITIM_VBP_OFS     = 16'hB03C;
	localparam logic [15:0] DSITIM_VFP_OFS     = 16'hB040;
	localparam logic [15:0] DSITIM_SWITCH_OFS  = 16'hB044;
	localparam logic [15:0] DSITIM_SPKT_OFS    = 16'hB048;

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [31:0] DSITIM_FUNC_RST    = 32'h0000_0001;
	localparam logic [31:0] DSITIM_IRQEN_MASK  = 32'hFFFF_7DFF;
	localparam logic [31:0] DSITIM_FUNC_MASK   = 32'h0000_E7FF;
	localparam logic [31:0] DSITIM_SPKT_MASK   = 32'h0000_00FF;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DSITIM_CTRL_RUN     = 0;
	localparam int DSITIM_CTRL_BTA     = 1;
	localparam int DSITIM_CTRL_PRST    = 2;
	localparam int DSITIM_ST_ACK_OK    = 24;
	localparam int DSITIM_ST_TA_TO     = 23;
	localparam int DSITIM_ST_LP_TO     = 22;
	localparam int DSITIM_ST_HS_TO     = 21;
	localparam int DSITIM_ACK_ERR_W    = 12;
	localparam int DSITIM_ST_RSVD_LOW  = 9;

	// Link state machine.
	typedef enum logic [2:0] {LS_STOP, LS_UP, LS_HS, LS_DOWN, LS_TA, LS_RX, LS_RST} dsitim_link_t;
	// Line and frame phases.
	typedef enum logic [1:0] {PH_SYNC, PH_BP, PH_ACT, PH_FP} dsitim_phase_t;

endpackage

// *** sim/dsitim_asserts.sv ***
// Concurrent checks on the ports of the link timing block.
`timescale 1ns/1ps
`default_nettype none
module dsitim_asserts
	import dsitim_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [15:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pix_ready,
	input wire logic        cmd_stall_r,
	input wire logic [3:0]  lane_en_r,
	input wire logic        hs_mode_r,
	input wire logic        stop_state_r,
	input wire logic        eot_r,
	input wire logic        bta_r,
	input wire logic [4:0]  cmd_width_bits_r,
	input wire logic [4:0]  video_bpp_r,
	input wire logic        format_bad_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// Port relations
	// ****
	a_apb_ready: assert property (psel && penable |-> pready) else $error("access without ready");
	a_unmapped_err: assert property (psel && penable && paddr > DSITIM_SPKT_OFS |-> pslverr)
		else $error("unmapped access without error");
	a_eot_stop: assert property (eot_r |-> ##[1:600] stop_state_r)
		else $error("no stop state after burst end");
	a_hs_stop: assert property (hs_mode_r |-> !stop_state_r) else $error("stop during burst");
	a_bta_lp: assert property (bta_r |-> !hs_mode_r) else $error("turnaround during burst");
	a_lane_mask: assert property (lane_en_r inside {4'h1, 4'h3, 4'h7, 4'hF})
		else $error("lane mask not contiguous");
	a_width_code: assert property (
		!format_bad_r |-> cmd_width_bits_r inside {5'h1, 5'h2, 5'h8, 5'h9, 5'h10} && video_bpp_r inside {5'h10, 5'h12, 5'h18})
		else $error("odd decode with good format");
	a_stall_full: assert property (!pix_ready |-> cmd_stall_r) else $error("full without stall");
	c_eot: cover property (eot_r);
	c_bta: cover property (bta_r);
	c_full: cover property (!pix_ready);
endmodule
bind dsitim_top dsitim_asserts chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .pix_ready,
	.cmd_stall_r, .lane_en_r, .hs_mode_r, .stop_state_r, .eot_r, .bta_r, .cmd_width_bits_r, .video_bpp_r,
	.format_bad_r);
`default_nettype wire

// *** sim/dsitim_panel.sv ***
// Behavioural display panel answering link turnarounds.
`timescale 1ns/1ps
`default_nettype none
module dsitim_panel (
	input  wire logic        pclk,
	input  wire logic        bta_r,
	input  wire logic [1:0]  mode,
	input  wire logic [11:0] err,
	output logic             link_byte_clk,
	output logic             peer_rx_active,
	output logic             peer_ack_valid,
	output logic [11:0]      peer_ack_err,
	output logic             busy
);
	// The byte clock is the host PHY's own, so it runs free at a phase unrelated to pclk.
	initial begin
		link_byte_clk = 1'b0;
		#7;
		forever #24 link_byte_clk = ~link_byte_clk;
	end
	// Mode 0 acknowledges, 1 stays silent, 2 takes the bus but never answers.
	initial begin
		{peer_rx_active, peer_ack_valid, busy} = 3'h0;
		peer_ack_err = 12'hFFF;
		forever begin
			@(posedge pclk);
			if (bta_r === 1'b1) begin
				busy <= 1'b1;
				repeat (10) @(posedge pclk);
				peer_rx_active <= mode != 2'h1;
				repeat (10) @(posedge pclk);
				peer_ack_valid <= mode == 2'h0;
				peer_ack_err <= err;
				repeat (300) @(posedge pclk);
				{peer_rx_active, peer_ack_valid, busy} <= 3'h0;
				peer_ack_err <= ~err;
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/dsitim_top_bench.sv ***
// Self-checking bench for the link timing and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module dsitim_top_bench
	import dsitim_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pix_valid, pready, pslverr, irq_r, busy;
	logic        link_byte_clk, peer_rx_active, peer_ack_valid, pix_ready, cmd_stall_r, lane_data_valid_r;
	logic        hs_mode_r, stop_state_r, eot_r, bta_r, format_bad_r, panel_reset_r, de_r;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, pix_data, lane_data_r, pexp;
	logic [11:0] peer_ack_err, err;
	logic [4:0]  cmd_width_bits_r, video_bpp_r;
	logic [3:0]  lane_en_r;
	logic [1:0]  cmd_vc_r, mode;
	int          miscompares, checked, pops, pushed;
	logic [31:0] msk [17] = '{32'hFFFF7DFF, 32'hE7FF, 32'hFFFFFF, 32'hFFFFFF, 32'h3F, 32'hFFFF, 32'hFFFFFFFF,
		32'h3, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFF};
	logic [31:0] stt [7] = '{32'h1, 32'h2, 32'h8, 32'h10, 32'h1000000, 32'h800000, 32'h400000};
	logic [4:0]  wexp [5] = '{5'h10, 5'h9, 5'h8, 5'h1, 5'h2};
	logic [4:0]  bexp [4] = '{5'h10, 5'h12, 5'h18, 5'h18};
	dsitim_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_r,
		.link_byte_clk, .peer_rx_active, .peer_ack_valid, .peer_ack_err, .pix_valid, .pix_data, .pix_ready,
		.cmd_stall_r, .lane_data_r, .lane_data_valid_r, .lane_en_r, .hs_mode_r, .stop_state_r, .eot_r, .bta_r,
		.panel_reset_r, .hsync_r(), .vsync_r(), .de_r, .cmd_vc_r, .video_vc_r(), .cmd_width_bits_r,
		.video_bpp_r, .format_bad_r);
	dsitim_panel panel (.pclk, .bta_r, .mode, .err, .link_byte_clk, .peer_rx_active, .peer_ack_valid,
		.peer_ack_err, .busy);
	// ****
	// Tasks
	// ****
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request stands until pready is seen at an edge.
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		cmp({pready, pslverr}, {1'b1, a > DSITIM_SPKT_OFS});
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask
	task automatic poll(input logic [31:0] e);
		logic [31:0] q;
		for (int n = 0; n < 300; n++) begin
			apb(1'b0, DSITIM_STAT_OFS, 32'h0, q);
			if ((q & e) != 32'h0) break;
		end
		cmp(q, e);
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Popped words must leave in the order they were pushed.
	always @(posedge pclk) begin
		if (lane_data_valid_r === 1'b1) begin
			cmp(lane_data_r, pexp);
			cmp({de_r, hs_mode_r}, 32'h3);
			pexp = pexp + 32'h1;
			pops++;
		end
	end
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
	initial begin
		{presetn, psel, penable, pwrite, pix_valid, paddr, pwdata, pix_data, pexp, err, mode} = 0;
		repeat (2) @(posedge pclk);
		cmp({stop_state_r, cmd_stall_r, lane_en_r, format_bad_r}, 32'h63);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 17; i++) begin
			rd(16'hB008 + 16'(4 * i), 32'(i == 1));
			wr(16'hB008 + 16'(4 * i), 32'hFFFFFFFF);
			rd(16'hB008 + 16'(4 * i), msk[i]);
			wr(16'hB008 + 16'(4 * i), 32'h0);
		end
		rd(16'hB0F0, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			wr(DSITIM_FUNC_OFS, {16'h0, 3'(i + 1), 2'h0, 4'(i % 4 + 1), 2'(i), 2'h0, 3'(i % 4 + 1)});
			@(posedge pclk);
			cmp({cmd_width_bits_r, video_bpp_r, cmd_vc_r}, {wexp[i], bexp[i % 4], 2'(i)});
			cmp(32'(lane_en_r), 32'((1 << (i % 4 + 1)) - 1));
		end
		wr(DSITIM_FUNC_OFS, 32'h81);
		@(posedge pclk);
		cmp({format_bad_r, cmd_width_bits_r}, 32'h20);
		wr(DSITIM_FUNC_OFS, 32'h2081);
		$display("test decode done");
		wr(DSITIM_TATO_OFS, 32'h14);
		wr(DSITIM_LPTO_OFS, 32'h14);
		wr(DSITIM_IRQEN_OFS, 32'hC00018);
		for (int i = 0; i < 7; i++) begin
			mode <= i < 5 ? 2'h0 : 2'(i - 4);
			err <= stt[i][11:0];
			wr(DSITIM_CTRL_OFS, 32'h2);
			poll(stt[i]);
			cmp(32'(irq_r), 32'(|(stt[i] & 32'hC00018)));
			wr(DSITIM_STAT_OFS, 32'hFFFFFFFF);
			@(posedge pclk);
			cmp(32'(irq_r), 32'h0);
			for (int n = 0; n < 400 && busy; n++) @(posedge pclk);
		end
		// A panel reset of two ticks must hold for a while and then give back stop state.
		wr(DSITIM_PRST_OFS, 32'h2);
		wr(DSITIM_CTRL_OFS, 32'h4);
		for (int n = 0; n < 100 && panel_reset_r !== 1'b1; n++) @(posedge pclk);
		repeat (15) @(posedge pclk);
		cmp(32'(panel_reset_r), 32'h1);
		repeat (30) @(posedge pclk);
		cmp({panel_reset_r, stop_state_r}, 32'h1);
		$display("test acknowledge done");
		wr(DSITIM_HSTO_OFS, 32'h3);
		// A long active area keeps the line end from closing the burst before the timeout.
		wr(DSITIM_HACT_OFS, 32'h10);
		wr(DSITIM_CTRL_OFS, 32'h1);
		poll(32'h200000);
		wr(DSITIM_CTRL_OFS, 32'h0);
		wr(DSITIM_STAT_OFS, 32'hFFFFFFFF);
		pix_valid <= 1'b1;
		repeat (40) begin
			@(posedge pclk);
			if (pix_ready === 1'b1) begin
				pushed++;
				pix_data <= pix_data + 32'h1;
			end
		end
		pix_valid <= 1'b0;
		cmp(32'(pushed), 32'h20);
		cmp(32'(cmd_stall_r), 32'h1);
		wr(DSITIM_HSTO_OFS, 32'hFFFFFF);
		wr(DSITIM_VRES_OFS, 32'h20008);
		wr(DSITIM_HACT_OFS, 32'h8);
		wr(DSITIM_CTRL_OFS, 32'h1);
		for (int n = 0; n < 20000 && pops < 32; n++) @(posedge pclk);
		cmp(32'(pops), 32'h20);
		wr(DSITIM_CTRL_OFS, 32'h0);
		cmp(32'(cmd_stall_r), 32'h0);
		// Seven free slots stall at the quarter mark but not at the seven-slot mark.
		pix_valid <= 1'b1;
		repeat (25) @(posedge pclk);
		pix_valid <= 1'b0;
		wr(DSITIM_WMARK_OFS, 32'h1);
		@(posedge pclk);
		cmp(32'(cmd_stall_r), 32'h1);
		wr(DSITIM_WMARK_OFS, 32'h2);
		@(posedge pclk);
		cmp(32'(cmd_stall_r), 32'h0);
		$display("test buffer done");
		final_report();
	end
endmodule
`default_nettype wire
